// File: rtl/fbod_ctrl.sv
// Purpose: host controller driving a parallel flash through its pins
// Assumes: APB slave for software; flash pins sampled on CLK
// Notes:   one access at a time; software polls the busy flag
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module fbod_ctrl #(
    parameter int ADDR_W = 22                          // word address width
) (
    input  wire logic              CLK,                // 25 MHz clock
    input  wire logic              RST,                // async reset, high
    input  wire logic              PSEL,               // apb select
    input  wire logic              PENABLE,            // apb access phase
    input  wire logic              PWRITE,             // apb direction
    input  wire logic [7:0]        PADDR,              // apb byte address
    input  wire logic [31:0]       PWDATA,             // apb write data
    output logic      [31:0]       PRDATA,             // apb read data
    output logic                   PREADY,             // apb ready
    output logic                   PSLVERR,            // apb error
    output logic      [ADDR_W-1:0] F_ADDR,             // flash address
    input  wire logic [15:0]       F_DQ_I,             // data lines in
    output logic      [15:0]       F_DQ_O,             // data lines out
    output logic                   F_DQ_OE,            // data drive enable
    output logic                   F_CE_N,             // chip enable
    output logic                   F_OE_N,             // output gate
    output logic                   F_WE_N,             // write strobe
    output logic                   F_RESET_N,          // hardware reset
    output logic                   F_WIDTH_SELECT,     // word when high
    output logic                   F_ACCEL_ELEVATED,   // request elevated accel level
    input  wire logic              F_READY_BUSY_N      // device ready
);
    initial begin
        if (ADDR_W < 2 || ADDR_W > 31) $error("ADDR_W out of range");
    end

    // ************************************************
    // state
    // ************************************************
    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_SETUP = 6'b000010,
        S_RD    = 6'b000100,
        S_WR    = 6'b001000,
        S_HOLD  = 6'b010000,
        S_RST   = 6'b100000
    } fbod_state_e;

    typedef struct packed {
        fbod_state_e               st;
        logic [fbod_pkg::FBOD_CNT_W-1:0] cnt;
        logic                      word;
        logic                      accel;
        logic                      rst_req;
        logic [ADDR_W-1:0]         addr;
        logic [15:0]               wdata;
        logic [15:0]               rdata;
        logic                      is_wr;
        logic                      ce_n;
        logic                      oe_n;
        logic                      we_n;
        logic                      dq_oe;
        logic                      reset_n;
        logic                      busy;
        logic [31:0]               prdata;
    } fbod_state_s;

    fbod_state_s s_q;
    fbod_state_s s_d;

    logic apb_access;
    logic apb_wr;
    logic unmapped;

    assign apb_access = PSEL && PENABLE;
    assign apb_wr     = apb_access && PWRITE;
    assign unmapped   = PADDR > fbod_pkg::FBOD_CMD_OFS || PADDR[1:0] != 2'h0;

    always_comb begin
        s_d = s_q;
        // ************************************************
        // register writes
        // ************************************************
        if (apb_wr) begin
            unique case (PADDR)
                fbod_pkg::FBOD_CTRL_OFS: begin
                    s_d.word    = PWDATA[fbod_pkg::FBOD_CTRL_WORD_BIT];
                    s_d.accel   = PWDATA[fbod_pkg::FBOD_CTRL_ACCEL_BIT];
                    s_d.rst_req = PWDATA[fbod_pkg::FBOD_CTRL_RST_BIT];
                end
                fbod_pkg::FBOD_ADDR_OFS: begin
                    s_d.addr = PWDATA[ADDR_W-1:0];
                end
                fbod_pkg::FBOD_WDATA_OFS: begin
                    s_d.wdata = PWDATA[15:0];
                end
                fbod_pkg::FBOD_CMD_OFS: begin
                    if (!s_q.busy && PWDATA[1:0] != 2'h0) begin
                        s_d.busy  = 1'b1;
                        s_d.is_wr = PWDATA[1:0] == fbod_pkg::FBOD_CMD_WRITE;
                        s_d.st    = S_SETUP;
                        s_d.cnt   = '0;
                    end
                end
                default: begin
                end
            endcase
        end
        s_d.prdata = '0;
        // decoded in the setup cycle so the word already stands when pready is sampled
        if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                fbod_pkg::FBOD_CTRL_OFS:  s_d.prdata = {29'h0, s_q.rst_req, s_q.accel, s_q.word};
                fbod_pkg::FBOD_ADDR_OFS:  s_d.prdata = 32'(s_q.addr);
                fbod_pkg::FBOD_WDATA_OFS: s_d.prdata = {16'h0, s_q.wdata};
                fbod_pkg::FBOD_RDATA_OFS: s_d.prdata = {16'h0, s_q.rdata};
                fbod_pkg::FBOD_STAT_OFS:  s_d.prdata = {30'h0, F_READY_BUSY_N, s_q.busy};
                default:                  s_d.prdata = '0;
            endcase
        end
        // ************************************************
        // flash pin sequencer
        // ************************************************
        unique case (s_q.st)
            S_IDLE: begin
                s_d.ce_n  = 1'b1;
                s_d.oe_n  = 1'b1;
                s_d.we_n  = 1'b1;
                s_d.dq_oe = 1'b0;
                if (s_q.rst_req) begin
                    s_d.rst_req = 1'b0;
                    s_d.reset_n = 1'b0;
                    s_d.busy    = 1'b1;
                    s_d.cnt     = '0;
                    s_d.st      = S_RST;
                end
            end
            S_SETUP: begin
                // chip enable leads data by tce
                s_d.ce_n = 1'b0;
                s_d.cnt  = '0;
                if (s_q.is_wr) begin
                    // write: gate held high, strobe low
                    s_d.oe_n  = 1'b1;
                    s_d.we_n  = 1'b0;
                    s_d.dq_oe = 1'b1;
                    s_d.st    = S_WR;
                end else begin
                    s_d.we_n = 1'b1;
                    s_d.oe_n = 1'b0;
                    s_d.st   = S_RD;
                end
            end
            S_RD: begin
                s_d.cnt = s_q.cnt + 1'b1;
                if (32'(s_q.cnt) + 1 >= fbod_pkg::FBOD_TCE_CYC) begin
                    // byte mode uses the low lane only
                    s_d.rdata = s_q.word ? F_DQ_I : {8'h00, F_DQ_I[7:0]};
                    s_d.st    = S_HOLD;
                end
            end
            S_WR: begin
                s_d.cnt = s_q.cnt + 1'b1;
                if (32'(s_q.cnt) + 1 >= fbod_pkg::FBOD_TWP_CYC) begin
                    s_d.we_n = 1'b1;
                    s_d.st   = S_HOLD;
                end
            end
            S_HOLD: begin
                s_d.ce_n  = 1'b1;
                s_d.oe_n  = 1'b1;
                s_d.we_n  = 1'b1;
                s_d.dq_oe = 1'b0;
                s_d.busy  = 1'b0;
                s_d.st    = S_IDLE;
            end
            S_RST: begin
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.reset_n == 1'b0 && 32'(s_q.cnt) + 1 >= fbod_pkg::FBOD_TRP_CYC) begin
                    s_d.reset_n = 1'b1;
                    s_d.cnt     = '0;
                end else if (s_q.reset_n && 32'(s_q.cnt) + 1 >= fbod_pkg::FBOD_TRH_CYC && F_READY_BUSY_N) begin
                    s_d.busy = 1'b0;
                    s_d.st   = S_IDLE;
                end
            end
            default: begin
                s_d.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q         <= '0;
            s_q.st      <= S_IDLE;
            s_q.word    <= fbod_pkg::FBOD_CTRL_RESET[fbod_pkg::FBOD_CTRL_WORD_BIT];
            s_q.ce_n    <= 1'b1;
            s_q.oe_n    <= 1'b1;
            s_q.we_n    <= 1'b1;
            s_q.reset_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign PREADY  = 1'b1;
    assign PSLVERR = apb_access && unmapped;
    assign PRDATA  = s_q.prdata;
    // prdata is registered at the end of the setup cycle and stands through the access phase
    assign F_ADDR  = s_q.addr;
    assign F_DQ_O  = s_q.word ? s_q.wdata : {s_q.addr[0], 7'h00, s_q.wdata[7:0]};
    // byte mode: top line carries the byte address
    assign F_DQ_OE = s_q.dq_oe || !s_q.word;
    assign F_CE_N  = s_q.ce_n;
    assign F_OE_N  = s_q.oe_n;
    assign F_WE_N  = s_q.we_n;
    assign F_RESET_N = s_q.reset_n;
    assign F_WIDTH_SELECT = s_q.word;
    // elevated level only in program cycles, never across a reset
    assign F_ACCEL_ELEVATED = s_q.accel && s_q.is_wr && (s_q.st == S_SETUP || s_q.st == S_WR || s_q.st == S_HOLD);

    // ************************************************
    // checks
    // ************************************************
    sequence s_rd_start;
        s_q.st == S_SETUP && !s_q.is_wr;
    endsequence

    property p_rd_pins;
        @(posedge CLK) disable iff (RST) s_rd_start |=> !F_CE_N && !F_OE_N && F_WE_N;
    endproperty
    a_rd_pins: assert property (p_rd_pins) else $error("read pins wrong");

    property p_wr_pins;
        @(posedge CLK) disable iff (RST) !F_WE_N |-> !F_CE_N && F_OE_N;
    endproperty
    a_wr_pins: assert property (p_wr_pins) else $error("write pins wrong");

    property p_no_gate_write;
        @(posedge CLK) disable iff (RST) !(!F_OE_N && !F_WE_N);
    endproperty
    a_no_gate_write: assert property (p_no_gate_write) else $error("gate and strobe low");

    property p_tce_wait;
        @(posedge CLK) disable iff (RST) s_rd_start |=> (s_q.st == S_RD) [*2];
    endproperty
    a_tce_wait: assert property (p_tce_wait) else $error("read sampled early");

    property p_rst_pulse;
        @(posedge CLK) disable iff (RST) $fell(F_RESET_N) |-> !F_RESET_N [*8] ##1 !F_RESET_N [*5];
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");

    property p_rst_busy;
        @(posedge CLK) disable iff (RST) (s_q.st == S_RST && !F_READY_BUSY_N) |=> s_q.busy;
    endproperty
    a_rst_busy: assert property (p_rst_busy) else $error("busy dropped early");

    property p_accel;
        @(posedge CLK) disable iff (RST) F_ACCEL_ELEVATED |-> F_OE_N && F_RESET_N;
    endproperty
    a_accel: assert property (p_accel) else $error("accel outside write");

    property p_width;
        @(posedge CLK) disable iff (RST) (F_WIDTH_SELECT && !F_OE_N) |-> !F_DQ_OE;
    endproperty
    a_width: assert property (p_width) else $error("lines driven during word read");
endmodule : fbod_ctrl

// File: rtl/fbod_pkg.sv
// Purpose: constants for the flash bus controller (host side)
// Assumes: 25 MHz CLK; flash pins driven synchronously
// Notes:   register map and bus timing figures live here
// What this block does
// - read: chip enable, output gate low
// - write: strobe and chip enable low, gate high
// - host applies accelerate only when programming
// - host waits chip-enable access after standby
package fbod_pkg;
    // ************************************************
    // register map (word aligned byte offsets)
    // ************************************************
    localparam logic [7:0] FBOD_CTRL_OFS  = 8'h00;
    localparam logic [7:0] FBOD_ADDR_OFS  = 8'h04;
    localparam logic [7:0] FBOD_WDATA_OFS = 8'h08;
    localparam logic [7:0] FBOD_RDATA_OFS = 8'h0c;
    localparam logic [7:0] FBOD_STAT_OFS  = 8'h10;
    localparam logic [7:0] FBOD_CMD_OFS   = 8'h14;
    // ctrl fields
    localparam int FBOD_CTRL_WORD_BIT  = 0;
    localparam int FBOD_CTRL_ACCEL_BIT = 1;
    localparam int FBOD_CTRL_RST_BIT   = 2;
    localparam logic [31:0] FBOD_CTRL_RESET = 32'h0000_0001;
    // command codes written to the command register
    localparam logic [1:0] FBOD_CMD_READ  = 2'h1;
    localparam logic [1:0] FBOD_CMD_WRITE = 2'h2;
    // ************************************************
    // timing
    // ************************************************
    localparam int FBOD_CLK_MHZ   = 25;
    localparam int FBOD_TCE_NS    = 70;
    localparam int FBOD_TACC_NS   = 70;
    localparam int FBOD_TWP_NS    = 35;
    localparam int FBOD_TRP_NS    = 500;
    localparam int FBOD_TRH_NS    = 50;
    localparam int FBOD_TCE_CYC   = (FBOD_TCE_NS * FBOD_CLK_MHZ + 999) / 1000;
    localparam int FBOD_TACC_CYC  = (FBOD_TACC_NS * FBOD_CLK_MHZ + 999) / 1000;
    localparam int FBOD_TWP_CYC   = (FBOD_TWP_NS * FBOD_CLK_MHZ + 999) / 1000;
    localparam int FBOD_TRP_CYC   = (FBOD_TRP_NS * FBOD_CLK_MHZ + 999) / 1000;
    localparam int FBOD_TRH_CYC   = (FBOD_TRH_NS * FBOD_CLK_MHZ + 999) / 1000;
    localparam int FBOD_CNT_W     = 8;
endpackage : fbod_pkg

// File: testbench/fbod_flash_model.sv
// Purpose: behavioural flash die behind the controller
// Assumes: sixteen words; command byte 90 enters code reads, f0 leaves
// Notes:   lines nobody drives show a pattern that toggles each cycle
`timescale 1ns/1ps
module fbod_flash_model #(
    parameter logic [15:0] ID_CODE = 16'h5a3c // arbitrary value
) (
    input  wire logic        clk,     // float pattern only
    input  wire logic [3:0]  addr,    // word address
    input  wire logic [15:0] dq_in,   // resolved data lines
    output logic      [15:0] dq_out,  // device drive
    input  wire logic        ce_n,    // chip enable
    input  wire logic        oe_n,    // output gate
    input  wire logic        we_n,    // write strobe
    input  wire logic        reset_n, // hardware reset
    input  wire logic        word,    // width select
    input  wire logic        accel,   // elevated level
    output logic             rb_n,    // ready busy
    output logic             bad,     // sticky misuse flag
    output logic             accel_at_wr // accel at last write
);
    logic [15:0] mem [16];
    logic        auto_q = 1'b0;
    logic        flt    = 1'b0;
    initial bad = 1'b0;
    initial rb_n = 1'b1;
    initial accel_at_wr = 1'b0;
    always @(posedge clk) flt <= ~flt;
    always @* begin
        dq_out = {8{flt, ~flt}};
        if (!ce_n && !oe_n && we_n && reset_n) begin
            if (word) dq_out = auto_q ? ID_CODE : mem[addr];
            else dq_out[7:0] = dq_in[15] ? mem[addr][15:8] : mem[addr][7:0];
        end
    end
    always @(negedge we_n) if (!ce_n && !oe_n) bad = 1'b1;
    always @(posedge we_n) if (!ce_n && oe_n && reset_n) begin
        accel_at_wr = accel;
        if (dq_in[7:0] == 8'h90) auto_q = 1'b1;
        else if (dq_in[7:0] == 8'hf0) auto_q = 1'b0;
        else begin
            if (word) mem[addr] = dq_in;
            else if (dq_in[15]) mem[addr][15:8] = dq_in[7:0];
            else mem[addr][7:0] = dq_in[7:0];
            rb_n = 1'b0;
            rb_n <= #400 1'b1;
        end
    end
    // reset back to array read, busy runs on
    always @(negedge reset_n) auto_q = 1'b0;
endmodule : fbod_flash_model

// File: testbench/tb.sv
// Purpose: apb level tests of the flash controller
// Assumes: design answers with zero wait, read data stands in the access phase
// Notes:   model flags any strobe issued with chip enable and the gate low
`timescale 1ns/1ps
module tb;
    logic        CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0]  PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, r;
    logic        PREADY, PSLVERR, F_DQ_OE, F_CE_N, F_OE_N, F_WE_N, F_RESET_N, ws, accel_pin, rb_n, bad, accel_at_wr, e;
    logic [21:0] F_ADDR;
    logic [15:0] dq_i, dq_o, mo;
    int          num_errors = 0, checks = 0, cyc = 0;
    // controller owns the top line in byte mode; low lines only while gate is high
    assign dq_i[15] = F_DQ_OE ? dq_o[15] : mo[15];
    assign dq_i[14:0] = (F_DQ_OE && F_OE_N) ? dq_o[14:0] : mo[14:0];
    fbod_ctrl DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .F_ADDR(F_ADDR), .F_DQ_I(dq_i),
        .F_DQ_O(dq_o), .F_DQ_OE(F_DQ_OE), .F_CE_N(F_CE_N), .F_OE_N(F_OE_N), .F_WE_N(F_WE_N),
        .F_RESET_N(F_RESET_N), .F_WIDTH_SELECT(ws), .F_ACCEL_ELEVATED(accel_pin), .F_READY_BUSY_N(rb_n));
    fbod_flash_model flash (.clk(CLK), .addr(F_ADDR[3:0]), .dq_in(dq_i), .dq_out(mo), .ce_n(F_CE_N),
        .oe_n(F_OE_N), .we_n(F_WE_N), .reset_n(F_RESET_N), .word(ws), .accel(accel_pin), .rb_n(rb_n), .bad(bad),
        .accel_at_wr(accel_at_wr));
    initial forever #20 CLK = ~CLK;
    // ************************************************
    // bus and compare tasks
    // ************************************************
    task test_done;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic er);
        @(posedge CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        er = PSLVERR;
        q = PRDATA;
        PSEL <= 0;
        PENABLE <= 0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        er;
        apb(1'b1, a, d, q, er);
    endtask : wr
    task cmp(input logic [31:0] g, input logic [31:0] x, input string m);
        checks++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, x);
        end
    endtask : cmp
    task cmpb(input logic g, input logic x, input string m);
        cmp({31'h0, g}, {31'h0, x}, m);
    endtask : cmpb
    task poll;
        repeat (100) begin
            apb(1'b0, fbod_pkg::FBOD_STAT_OFS, 32'h0, r, e);
            if (r[0] === 1'b0) break;
        end
        cmpb(r[0], 1'b0, "busy stuck");
    endtask : poll
    // one flash cycle, then the read data register
    task fop(input logic [1:0] c, input logic [7:0] a, input logic [15:0] d);
        wr(fbod_pkg::FBOD_ADDR_OFS, {24'h0, a});
        wr(fbod_pkg::FBOD_WDATA_OFS, {16'h0, d});
        wr(fbod_pkg::FBOD_CMD_OFS, {30'h0, c});
        poll;
        apb(1'b0, fbod_pkg::FBOD_RDATA_OFS, 32'h0, r, e);
    endtask : fop
    // ************************************************
    // tests
    // ************************************************
    initial begin
        repeat (6) @(posedge CLK);
        RST <= 0;
        @(posedge CLK);
        #1 cmpb(F_CE_N & F_OE_N & F_WE_N & F_RESET_N, 1'b1, "idle pins");
        apb(1'b0, fbod_pkg::FBOD_CTRL_OFS, 32'h0, r, e);
        cmp(r, fbod_pkg::FBOD_CTRL_RESET, "ctrl reset");
        fop(fbod_pkg::FBOD_CMD_WRITE, 8'h03, 16'ha55a);
        fop(fbod_pkg::FBOD_CMD_READ, 8'h03, 16'h0);
        cmp(r & 32'hffff, 32'ha55a, "word read");
        $display("word test done");
        wr(fbod_pkg::FBOD_CTRL_OFS, 32'h0);
        fop(fbod_pkg::FBOD_CMD_WRITE, 8'h06, 16'h003c);
        fop(fbod_pkg::FBOD_CMD_WRITE, 8'h07, 16'h00c3);
        fop(fbod_pkg::FBOD_CMD_READ, 8'h06, 16'h0);
        cmp(r & 32'hff, 32'h3c, "low byte");
        fop(fbod_pkg::FBOD_CMD_READ, 8'h07, 16'h0);
        cmp(r & 32'hff, 32'hc3, "high byte");
        $display("byte test done");
        wr(fbod_pkg::FBOD_CTRL_OFS, 32'h3);
        fop(fbod_pkg::FBOD_CMD_WRITE, 8'h05, 16'h1234);
        cmpb(accel_at_wr, 1'b1, "accel at write");
        cmpb(accel_pin, 1'b0, "accel after write");
        apb(1'b0, fbod_pkg::FBOD_STAT_OFS, 32'h0, r, e);
        cmpb(r[1], 1'b0, "pin busy");
        repeat (12) @(posedge CLK);
        apb(1'b0, fbod_pkg::FBOD_STAT_OFS, 32'h0, r, e);
        cmpb(r[1], 1'b1, "pin ready");
        wr(fbod_pkg::FBOD_CTRL_OFS, 32'h1);
        // reset requested while the program still holds the busy pin low
        wr(fbod_pkg::FBOD_ADDR_OFS, 32'h9);
        wr(fbod_pkg::FBOD_WDATA_OFS, 32'hbeef);
        wr(fbod_pkg::FBOD_CMD_OFS, {30'h0, fbod_pkg::FBOD_CMD_WRITE});
        wr(fbod_pkg::FBOD_CTRL_OFS, 32'h5);
        poll;
        cmpb(r[1], 1'b1, "ready after reset");
        $display("accel test done");
        fop(fbod_pkg::FBOD_CMD_WRITE, 8'h00, 16'h0090);
        fop(fbod_pkg::FBOD_CMD_READ, 8'h05, 16'h0);
        cmp(r & 32'hffff, 32'h5a3c, "code read");
        fop(fbod_pkg::FBOD_CMD_WRITE, 8'h00, 16'h00f0);
        fop(fbod_pkg::FBOD_CMD_READ, 8'h05, 16'h0);
        cmp(r & 32'hffff, 32'h1234, "array again");
        fop(fbod_pkg::FBOD_CMD_WRITE, 8'h00, 16'h0090);
        wr(fbod_pkg::FBOD_CTRL_OFS, 32'h5);
        poll;
        fop(fbod_pkg::FBOD_CMD_READ, 8'h05, 16'h0);
        cmp(r & 32'hffff, 32'h1234, "read after reset");
        cmpb(F_CE_N & F_RESET_N, 1'b1, "standby pins");
        $display("mode test done");
        apb(1'b0, 8'h20, 32'h0, r, e);
        cmpb(e, 1'b1, "unmapped");
        apb(1'b1, 8'h02, 32'h0, r, e);
        cmpb(e, 1'b1, "misaligned");
        cmpb(bad, 1'b0, "strobe with gate");
        $display("bus test done");
        test_done;
    end
endmodule : tb
